// >>> sepr_top.sv
`timescale 1ns/1ps
`include "sepr_regs.svh"

module sepr_top
    import sepr_pkg::*;
#(
    parameter int         WRITE_CYCLES = `SEPR_WRITE_CYC,
    // Arbitrary value, set to suit the system
    parameter logic [3:0] DEVICE_CODE  = 4'h5
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Bus clock pin
    input  wire logic       scl,
    // Bus data pin, open drain
    input  wire logic       sdaIn,
    output wire logic       sdaOut,
    output wire logic       sdaOeN,
    // Straps
    input  wire logic [2:0] chipSelectStraps,
    input  wire logic       writeGuard,
    // Status
    output wire logic       writeBusy
);

    ////////////////////////////////////////////////////////////////////////////

    localparam logic [`SEPR_PROG_CNT_W-1:0] PROG_LAST =
        `SEPR_PROG_CNT_W'(WRITE_CYCLES - 1);
    localparam logic [`SEPR_PROG_CNT_W-1:0] PAGE_LAST =
        `SEPR_PROG_CNT_W'(`SEPR_PAGE_BYTES - 1);

    sepr_top_state_t r;
    sepr_top_state_t next_r;

    logic [7:0] mem     [0:`SEPR_MEM_BYTES-1];
    logic [7:0] pageBuf [0:`SEPR_PAGE_BYTES-1];

    logic                    bufWe;
    logic [`SEPR_PAGE_W-1:0] bufIdx;
    logic [7:0]              bufData;
    logic                    memWe;
    logic [`SEPR_ADDR_W-1:0] memIdx;
    logic [`SEPR_PAGE_W-1:0] commitIdx;
    logic [7:0]              memRdata;

    ////////////////////////////////////////////////////////////////////////////
    // Input filtering, synchronisers live inside the filters

    sepr_filt_if sclIf ();
    sepr_filt_if sdaIf ();

    assign sclIf.rawIn = scl;
    assign sdaIf.rawIn = sdaIn;

    sepr_glitch_filter sclFilter (
        .clk   (clk),
        .reset (reset),
        .link  (sclIf.filt)
    );

    sepr_glitch_filter sdaFilter (
        .clk   (clk),
        .reset (reset),
        .link  (sdaIf.filt)
    );

    logic sclC;
    logic sdaC;
    logic sclRise;
    logic sclFall;
    logic startEv;
    logic stopEv;
    logic devMatch;

    assign sclC     = sclIf.cleanOut;
    assign sdaC     = sdaIf.cleanOut;
    assign sclRise  = sclC && !r.sclPrev;
    assign sclFall  = !sclC && r.sclPrev;
    assign startEv  = sclC && r.sclPrev && r.sdaPrev && !sdaC;
    assign stopEv   = sclC && r.sclPrev && !r.sdaPrev && sdaC;
    assign devMatch = (r.shift[`SEPR_CODE_HI:`SEPR_CODE_LO] == DEVICE_CODE)
                   && (r.shift[`SEPR_SEL_HI:`SEPR_SEL_LO] == r.strapSync2);

    assign memRdata  = mem[r.addr];
    assign commitIdx = r.progCnt[`SEPR_PAGE_W-1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_r  = r;
        bufWe   = 1'b0;
        bufIdx  = r.addr[`SEPR_PAGE_W-1:0];
        bufData = r.shift;
        memWe   = 1'b0;
        memIdx  = {r.progPage, commitIdx};

        next_r.strapSync1 = chipSelectStraps;
        next_r.strapSync2 = r.strapSync1;
        next_r.guardSync1 = writeGuard;
        next_r.guardSync2 = r.guardSync1;
        next_r.sclPrev    = sclC;
        next_r.sdaPrev    = sdaC;

        // Programming cycle: commit the page, then wait out the time
        if (r.busy) begin
            next_r.progCnt = r.progCnt + 1'b1;
            if (r.progCnt <= PAGE_LAST && r.pageMask[commitIdx]) begin
                memWe = 1'b1;
            end
            if (r.progCnt == PROG_LAST) begin
                next_r.busy     = 1'b0;
                next_r.pageMask = '0;
            end
        end

        if (!r.ready) begin
            // Bus must sit idle high before any frame counts
            next_r.ready = sclC && sdaC;
            next_r.state = ST_IDLE;
            next_r.drive = 1'b0;
        end else if (startEv) begin
            next_r.state  = ST_RX;
            next_r.stage  = STG_DEV;
            next_r.bitCnt = '0;
            next_r.drive  = 1'b0;
            if (!r.busy) begin
                // Unfinished page is never programmed
                next_r.pageMask = '0;
            end
        end else if (stopEv) begin
            next_r.state = ST_IDLE;
            next_r.drive = 1'b0;
            if (!r.busy) begin
                if (r.state == ST_RX && r.stage == STG_DATA && r.bitCnt == `SEPR_STOP_BIT_CNT
                    && r.pageMask != '0) begin
                    next_r.busy     = 1'b1;
                    next_r.progCnt  = '0;
                    next_r.progPage = r.addr[`SEPR_ADDR_W-1:`SEPR_PAGE_W];
                end else begin
                    next_r.pageMask = '0;
                end
            end
        end else begin
            case (r.state)
                ST_RX: begin
                    if (sclRise && r.bitCnt != `SEPR_BYTE_BITS) begin
                        next_r.shift  = {r.shift[6:0], sdaC};
                        next_r.bitCnt = r.bitCnt + 1'b1;
                    end else if (sclFall && r.bitCnt == `SEPR_BYTE_BITS) begin
                        next_r.bitCnt = '0;
                        case (r.stage)
                            STG_DEV: begin
                                if (!devMatch) begin
                                    next_r.state = ST_IDLE;
                                end else if (r.busy) begin
                                    // Poll answer: line stays released
                                    next_r.state = ST_IDLE;
                                end else begin
                                    next_r.readMode = r.shift[`SEPR_RW_BIT];
                                    next_r.drive    = 1'b1;
                                    next_r.state    = ST_ACK;
                                end
                            end
                            STG_ADDR_HI: begin
                                next_r.addr[`SEPR_ADDR_W-1:8] = r.shift[6:0];
                                next_r.drive = 1'b1;
                                next_r.state = ST_ACK;
                            end
                            STG_ADDR_LO: begin
                                next_r.addr[7:0] = r.shift;
                                next_r.drive = 1'b1;
                                next_r.state = ST_ACK;
                            end
                            default: begin
                                if (r.guardSync2) begin
                                    // No ack and nothing loaded
                                    next_r.pageMask = '0;
                                    next_r.state    = ST_WAIT;
                                end else begin
                                    bufWe = 1'b1;
                                    next_r.pageMask[bufIdx] = 1'b1;
                                    next_r.addr[`SEPR_PAGE_W-1:0] =
                                        r.addr[`SEPR_PAGE_W-1:0] + 1'b1;
                                    next_r.drive = 1'b1;
                                    next_r.state = ST_ACK;
                                end
                            end
                        endcase
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        next_r.drive = 1'b0;
                        if (r.stage == STG_DEV && r.readMode) begin
                            // First read byte leaves on this same edge
                            next_r.txByte = memRdata;
                            next_r.drive  = !memRdata[7];
                            next_r.addr   = r.addr + 1'b1;
                            next_r.bitCnt = '0;
                            next_r.state  = ST_TX;
                        end else begin
                            next_r.state = ST_RX;
                            if (r.stage != STG_DATA) begin
                                next_r.stage = sepr_stage_t'(r.stage + 1'b1);
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (sclFall) begin
                        if (r.bitCnt == `SEPR_LAST_BIT) begin
                            next_r.drive = 1'b0;
                            next_r.state = ST_RACK;
                        end else begin
                            next_r.txByte = {r.txByte[6:0], 1'b0};
                            next_r.drive  = !r.txByte[6];
                            next_r.bitCnt = r.bitCnt + 1'b1;
                        end
                    end
                end
                ST_RACK: begin
                    if (sclRise) begin
                        next_r.masterAck = !sdaC;
                    end else if (sclFall) begin
                        if (r.masterAck) begin
                            next_r.txByte = memRdata;
                            next_r.drive  = !memRdata[7];
                            next_r.addr   = r.addr + 1'b1;
                            next_r.bitCnt = '0;
                            next_r.state  = ST_TX;
                        end else begin
                            // Line left open until stop or start
                            next_r.state = ST_WAIT;
                        end
                    end
                end
                default: begin
                    next_r.drive = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{state:      ST_IDLE,
                   stage:      STG_DEV,
                   bitCnt:     '0,
                   shift:      '0,
                   txByte:     '0,
                   drive:      1'b0,
                   readMode:   1'b0,
                   masterAck:  1'b0,
                   addr:       '0,
                   pageMask:   '0,
                   busy:       1'b0,
                   progCnt:    '0,
                   progPage:   '0,
                   strapSync1: '0,
                   strapSync2: '0,
                   guardSync1: 1'b0,
                   guardSync2: 1'b0,
                   sclPrev:    1'b1,
                   sdaPrev:    1'b1,
                   ready:      1'b0};
        end else begin
            r <= next_r;
        end
    end

    // Arrays carry no reset; contents are only defined once written
    always_ff @(posedge clk) begin
        if (bufWe) begin
            pageBuf[bufIdx] <= bufData;
        end
    end

    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[memIdx] <= pageBuf[commitIdx];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign sdaOut    = 1'b0;
    assign sdaOeN    = !r.drive;
    assign writeBusy = r.busy;

endmodule

// >>> sepr_regs.svh
`ifndef SEPR_REGS_SVH
`define SEPR_REGS_SVH

// Clock and bus timing
`define SEPR_CLK_PERIOD_NS  25
`define SEPR_GLITCH_NS      50
`define SEPR_GLITCH_CYC     ((`SEPR_GLITCH_NS + `SEPR_CLK_PERIOD_NS - 1) / `SEPR_CLK_PERIOD_NS)
`define SEPR_GLITCH_CNT_W   2
`define SEPR_WRITE_MS       5
`define SEPR_WRITE_CYC      ((`SEPR_WRITE_MS * 1000000) / `SEPR_CLK_PERIOD_NS)
`define SEPR_PROG_CNT_W     18

// Array shape
`define SEPR_ADDR_W         15
`define SEPR_PAGE_W         6
`define SEPR_PAGE_BYTES     64
`define SEPR_MEM_BYTES      32768
`define SEPR_BYTE_BITS      4'h8
`define SEPR_LAST_BIT       4'h7
// Bits counted when a stop follows a byte's acknowledge (the stop's own clock rise)
`define SEPR_STOP_BIT_CNT   4'h1

// Device address word fields
`define SEPR_CODE_HI        7
`define SEPR_CODE_LO        4
`define SEPR_SEL_HI         3
`define SEPR_SEL_LO         1
`define SEPR_RW_BIT         0

`endif

// >>> sepr_pkg.sv
`include "sepr_regs.svh"

package sepr_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_RACK,
        ST_WAIT
    } sepr_state_t;

    typedef enum logic [1:0] {
        STG_DEV,
        STG_ADDR_HI,
        STG_ADDR_LO,
        STG_DATA
    } sepr_stage_t;

    typedef struct packed {
        logic                          sync1;
        logic                          sync2;
        logic                          clean;
        logic [`SEPR_GLITCH_CNT_W-1:0] cnt;
    } sepr_filt_state_t;

    typedef struct packed {
        sepr_state_t                 state;
        sepr_stage_t                 stage;
        logic [3:0]                  bitCnt;
        logic [7:0]                  shift;
        logic [7:0]                  txByte;
        logic                        drive;
        logic                        readMode;
        logic                        masterAck;
        logic [`SEPR_ADDR_W-1:0]     addr;
        logic [`SEPR_PAGE_BYTES-1:0] pageMask;
        logic                        busy;
        logic [`SEPR_PROG_CNT_W-1:0] progCnt;
        logic [8:0]                  progPage;
        logic [2:0]                  strapSync1;
        logic [2:0]                  strapSync2;
        logic                        guardSync1;
        logic                        guardSync2;
        logic                        sclPrev;
        logic                        sdaPrev;
        logic                        ready;
    } sepr_top_state_t;

endpackage

// >>> sepr_filt_if.sv
`timescale 1ns/1ps

interface sepr_filt_if;
    logic rawIn;
    logic cleanOut;
    modport filt (input rawIn, output cleanOut);
    modport user (output rawIn, input cleanOut);
endinterface

// >>> sepr_glitch_filter.sv
`timescale 1ns/1ps
`include "sepr_regs.svh"

module sepr_glitch_filter
    import sepr_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic reset,
    // Pin in, clean level out
    sepr_filt_if.filt link
);

    localparam logic [`SEPR_GLITCH_CNT_W-1:0] GLITCH_LAST =
        `SEPR_GLITCH_CNT_W'(`SEPR_GLITCH_CYC - 1);

    sepr_filt_state_t r;
    sepr_filt_state_t next_r;

    always_comb begin
        next_r = r;
        next_r.sync1 = link.rawIn;
        next_r.sync2 = r.sync1;
        // A level must hold for the full window before it is believed
        if (r.sync2 == r.clean) begin
            next_r.cnt = '0;
        end else if (r.cnt == GLITCH_LAST) begin
            next_r.clean = r.sync2;
            next_r.cnt   = '0;
        end else begin
            next_r.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '{sync1: 1'b1, sync2: 1'b1, clean: 1'b1, cnt: '0};
        end else begin
            r <= next_r;
        end
    end

    assign link.cleanOut = r.clean;

endmodule

// >>> sepr_top_properties.sv
`timescale 1ns/1ps

module sepr_top_properties #(
    parameter int WRITE_CYCLES = 200000
)
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Link pins
    input wire logic       scl,
    input wire logic       sdaIn,
    input wire logic       sdaOut,
    input wire logic       sdaOeN,
    // Straps and status
    input wire logic [2:0] chipSelectStraps,
    input wire logic       writeGuard,
    input wire logic       writeBusy
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (reset);

    // Busy run length, wide enough for a full-length cycle
    logic [31:0] busyLen;

    always_ff @(posedge clk or posedge reset) begin
        if (reset)
            busyLen <= 32'h0;
        else
            busyLen <= writeBusy ? busyLen + 32'h1 : 32'h0;
    end

    ////////////////////////////////////////
    reset_idle_a: assert property ($fell(reset) |-> (sdaOeN && !writeBusy)[*8])
        else $error("outputs not idle after reset");
    busy_max_a: assert property (busyLen <= WRITE_CYCLES)
        else $error("programming cycle too long");
    busy_hold_a: assert property ($rose(writeBusy) |=> writeBusy[*8])
        else $error("programming cycle cut short");
    busy_quiet_a: assert property (writeBusy && $past(writeBusy) |-> sdaOeN)
        else $error("bus answered while programming");
    busy_on_stop_a: assert property ($rose(writeBusy) |-> scl && sdaIn)
        else $error("programming began without a stop");
    // Bench holds the guard steady across a frame
    guard_block_a: assert property ($rose(writeBusy) |-> !$past(writeGuard, 8))
        else $error("programming while guarded");
    oe_hold_a: assert property ($changed(sdaOeN) |=> $stable(sdaOeN)[*6])
        else $error("data bit did not stand");
    oe_release_a: assert property ($fell(sdaOeN) |-> ##[1:120] sdaOeN)
        else $error("data line held too long");
    drive_low_a: assert property (!sdaOeN |-> !sdaOut)
        else $error("driven level not low");

    cover property ($rose(writeBusy));
    cover property ($fell(writeBusy));
    cover property ($fell(sdaOeN));
endmodule

bind sepr_top sepr_top_properties #(.WRITE_CYCLES(WRITE_CYCLES)) props_u (
    .clk              (clk),
    .reset            (reset),
    .scl              (scl),
    .sdaIn            (sdaIn),
    .sdaOut           (sdaOut),
    .sdaOeN           (sdaOeN),
    .chipSelectStraps (chipSelectStraps),
    .writeGuard       (writeGuard),
    .writeBusy        (writeBusy)
);

// >>> sepr_bus_ctrl.sv
`timescale 1ns/1ps

module sepr_bus_ctrl (
    // Clock
    input  wire logic clk,
    // Link pins
    output var  logic scl,
    output var  logic sdaDrv,
    input  wire logic sdaWire
);
    logic [7:0] resVal;
    logic       glitch;
    event       resEv;

    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
        glitch = 1'b0;
        resVal = 8'h00;
    end

    ////////////////////////////////////////
    task automatic waitClk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Low phase stretched past the device's answer lag of about five cycles
    task automatic bitIo(input logic b, output logic r);
        waitClk(2);
        sdaDrv = b;
        waitClk(3);
        // Narrow clock spike while low; unfiltered it would add a bit
        scl = glitch;
        waitClk(1);
        scl = 1'b0;
        waitClk(2);
        scl = 1'b1;
        waitClk(1);
        // Narrow dip while clock high; unfiltered it would read as a start
        sdaDrv = b & ~glitch;
        waitClk(1);
        sdaDrv = b;
        waitClk(1);
        r = sdaWire;
        waitClk(1);
        scl = 1'b0;
    endtask

    task automatic start();
        waitClk(2);
        sdaDrv = 1'b1;
        waitClk(6);
        scl = 1'b1;
        waitClk(4);
        sdaDrv = 1'b0;
        waitClk(4);
        scl = 1'b0;
    endtask

    task automatic stop();
        waitClk(2);
        sdaDrv = 1'b0;
        waitClk(6);
        scl = 1'b1;
        waitClk(4);
        sdaDrv = 1'b1;
        waitClk(4);
    endtask

    task automatic sendByte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitIo(d[i], r);
        bitIo(1'b1, r);
        resVal = {7'h00, r};
        ->resEv;
    endtask

    task automatic getByte(input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitIo(1'b1, r);
            resVal[i] = r;
        end
        ->resEv;
        bitIo(nack, r);
    endtask
endmodule

// >>> test_serial_eeprom_page_write_and_read.sv
`timescale 1ns/1ps

module test_serial_eeprom_page_write_and_read;
    // Arbitrary device type code
    localparam logic [3:0] DEV = 4'h5;

    typedef struct {
        string      name;
        logic [7:0] val;
    } sepr_note_t;

    logic       clk;
    logic       reset;
    logic       sclPin;
    logic       ctrlSda;
    logic       sdaOut;
    logic       sdaOeN;
    logic [2:0] straps;
    logic       writeGuard;
    logic       writeBusy;
    wire        sdaWire;
    logic [7:0] mem [32768];
    sepr_note_t expQ [$];
    sepr_note_t e;
    int         failures;
    int         compares;
    int         cycles;

    // Open drain wire with pull-up
    assign sdaWire = ctrlSda & (sdaOeN | sdaOut);

    sepr_top #(.WRITE_CYCLES(200), .DEVICE_CODE(DEV)) dut_u (
        .clk              (clk),
        .reset            (reset),
        .scl              (sclPin),
        .sdaIn            (sdaWire),
        .sdaOut           (sdaOut),
        .sdaOeN           (sdaOeN),
        .chipSelectStraps (straps),
        .writeGuard       (writeGuard),
        .writeBusy        (writeBusy)
    );

    sepr_bus_ctrl ctrl_u (
        .clk     (clk),
        .scl     (sclPin),
        .sdaDrv  (ctrlSda),
        .sdaWire (sdaWire)
    );

    always #12.5 clk = ~clk;

    ////////////////////////////////////////
    task automatic test_done();
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
        compares++;
        if (g !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, x, g);
        end
    endtask

    task automatic note(input string n, input logic [7:0] v);
        expQ.push_back('{n, v});
    endtask

    task automatic sendExp(input logic [7:0] d, input logic a);
        note("ack", {7'h00, a});
        ctrl_u.sendByte(d);
    endtask

    task automatic header(input logic [14:0] a);
        ctrl_u.start();
        sendExp({DEV, straps, 1'b0}, 1'b0);
        sendExp({1'b1, a[14:8]}, 1'b0);
        sendExp(a[7:0], 1'b0);
    endtask

    task automatic poll(input logic busyNow);
        int n;
        n = 0;
        repeat (8) @(negedge clk);
        while (!busyNow && writeBusy !== 1'b0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        ctrl_u.start();
        sendExp({DEV, straps, 1'b0}, busyNow);
        ctrl_u.stop();
    endtask

    task automatic curRead(input logic [14:0] a, input int n);
        ctrl_u.start();
        sendExp({DEV, straps, 1'b1}, 1'b0);
        for (int k = 0; k < n; k++) begin
            note("data", mem[15'(a + k)]);
            ctrl_u.getByte(k == n - 1);
        end
        ctrl_u.stop();
    endtask

    task automatic randRead(input logic [14:0] a, input int n);
        header(a);
        curRead(a, n);
    endtask

    // Result watcher: oldest note against each byte or acknowledge seen
    always begin
        @(ctrl_u.resEv);
        if (expQ.size() == 0)
            chk("unexpected", 8'hXX, ctrl_u.resVal);
        else begin
            e = expQ.pop_front();
            chk(e.name, e.val, ctrl_u.resVal);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            test_done();
        end
    end

    ////////////////////////////////////////
    initial begin
        logic [7:0] d;
        logic       r;
        clk = 1'b0;
        reset = 1'b1;
        writeGuard = 1'b1;
        failures = 0;
        compares = 0;
        cycles = 0;
        void'($urandom(79188));
        straps = 3'($urandom());
        repeat (20) @(negedge clk);
        reset = 1'b0;
        repeat (10) @(negedge clk);
        header(15'h0000);
        sendExp(8'($urandom()), 1'b1);
        ctrl_u.stop();
        repeat (8) @(negedge clk);
        chk("busy", 8'h00, {7'h00, writeBusy});
        writeGuard = 1'b0;
        d = 8'($urandom());
        mem[0] = d;
        header(15'h0000);
        sendExp(d, 1'b0);
        ctrl_u.stop();
        poll(1'b1);
        poll(1'b0);
        header(15'h0040);
        sendExp(8'($urandom()), 1'b0);
        repeat (3) ctrl_u.bitIo(1'b0, r);
        ctrl_u.stop();
        repeat (8) @(negedge clk);
        chk("busy", 8'h00, {7'h00, writeBusy});
        ctrl_u.glitch = 1'b1;
        header(15'h7FFE);
        for (int k = 0; k < 66; k++) begin
            d = 8'($urandom());
            mem[{9'h1FF, 6'(62 + k)}] = d;
            sendExp(d, 1'b0);
        end
        ctrl_u.glitch = 1'b0;
        ctrl_u.stop();
        poll(1'b0);
        curRead(15'h7FC0, 2);
        randRead(15'h7FFF, 1);
        curRead(15'h0000, 1);
        randRead(15'h7FFE, 3);
        ctrl_u.start();
        sendExp({DEV, ~straps, 1'b0}, 1'b1);
        ctrl_u.stop();
        ctrl_u.start();
        sendExp({~DEV, straps, 1'b1}, 1'b1);
        ctrl_u.stop();
        repeat (20) @(negedge clk);
        chk("pending", 8'h00, 8'(expQ.size()));
        test_done();
    end
endmodule
